// File: bench/pgbx_framer.sv
// Upstream framer model: transmit word source and receive word sink.
`timescale 1ns/1ns
module pgbx_framer (
  input  wire logic                 mclk,
  input  wire logic                 rst_b,
  input  wire logic                 stall,
  input  wire logic                 rx_word_valid,
  input  wire pgbx_pkg::pgbx_word_t rx_word,
  output logic                      rx_word_ready,
  output logic [15:0]               tx_data,
  output logic                      tx_pclk
);
  import pgbx_pkg::*;

  //----------------------------------------------------------------
  // State
  //----------------------------------------------------------------
  logic [3:0] ph_ff;          // Position inside the 16-cycle word slot.
  pgbx_word_t got[$];         // Words taken from the receive side.

  // The sink refuses words while the bench asks it to stall.
  assign rx_word_ready = !stall;

  // Word slots last one byte period, so data keeps a fixed phase to
  // the serializer; a slower source would starve the shifter.
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ph_ff   <= 4'h0;
      tx_pclk <= 1'b0;
      tx_data <= 16'h0000;
    end else begin
      ph_ff   <= ph_ff + 4'h1;
      tx_pclk <= (ph_ff < 4'h8);
      // New data rises together with the parallel clock.
      if (ph_ff == 4'h0) begin
        tx_data <= tx_data + 16'h3b5d;
      end
    end
  end

  // Collect every word handed over on a valid and ready edge.
  always @(posedge mclk) begin
    if (rst_b && rx_word_valid && rx_word_ready) begin
      got.push_back(rx_word);
    end
  end
endmodule : pgbx_framer

// File: bench/tb.sv
// Self-checking testbench of the gearbox core with its framer model.
`timescale 1ns/1ns
module tb;
  import pgbx_pkg::*;

  //----------------------------------------------------------------
  // Signals
  //----------------------------------------------------------------
  logic        mclk, rst_b, strobe, sdata, refclk, stall;
  logic        valid, ready, rclk, fref, ovr, dclk, txs, bclk, pclk;
  pgbx_rate_t  rate;          // Selected line rate.
  pgbx_word_t  word;          // Word shown to the framer.
  logic [23:0] khz;           // Reported bit rate.
  logic [15:0] tdat;          // Framer transmit word.
  int          err_count, n_checks;
  int          rclk_n;        // Receive word clock changes seen.
  logic        rclk_seen;     // Last sample of the receive word clock.

  pgbx_top pgbx_top_i (.mclk(mclk), .rst_b(rst_b), .rate_sel(rate),
    .rx_serial_data(sdata), .rx_bit_strobe(strobe),
    .rx_reference_clock(refclk), .rx_word_ready(ready),
    .rx_word_valid(valid), .rx_parallel_data_out(word),
    .rx_parallel_out_clock(rclk), .rx_force_ref(fref),
    .rx_bit_rate_khz(khz), .rx_overrun(ovr),
    .rx_ref_derived_clock(dclk), .tx_parallel_data_in(tdat),
    .tx_parallel_in_clock(pclk), .tx_serial_data(txs),
    .tx_byte_clock_out(bclk));

  pgbx_framer pgbx_framer_i (.mclk(mclk), .rst_b(rst_b), .stall(stall),
    .rx_word_valid(valid), .rx_word(word), .rx_word_ready(ready),
    .tx_data(tdat), .tx_pclk(pclk));

  always #4 mclk = ~mclk;

  //----------------------------------------------------------------
  // Shared tasks
  //----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // Serial bits go MSB first, one strobe per cycle.
  task automatic send_word(input logic [15:0] w);
    for (int i = 15; i >= 0; i--) begin
      @(posedge mclk);
      #1;
      if (rclk !== rclk_seen) rclk_n++;
      rclk_seen = rclk;
      strobe = 1'b1;
      sdata  = w[i];
    end
  endtask : send_word

  // Drop the strobe and let n cycles pass.
  task automatic idle(input int n);
    @(posedge mclk);
    #1;
    strobe = 1'b0;
    repeat (n) @(posedge mclk);
    #1;
  endtask : idle

  task automatic close_out();
    $display("checks=%0d errors=%0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : close_out

  //----------------------------------------------------------------
  // Scenarios
  //----------------------------------------------------------------
  // Every rate code maps to its bit rate; code 3 falls back to LAN.
  task automatic t_rates();
    logic [23:0] exp [4];
    exp = '{LAN_KHZ, WAN_KHZ, FEC_KHZ, LAN_KHZ};
    for (int r = 0; r < 4; r++) begin
      rate = pgbx_rate_t'(r[1:0]);
      repeat (2) @(posedge mclk);
      #1;
      check(32'(khz), 32'(exp[r]));
    end
    rate = RATE_LAN;
  endtask : t_rates

  // A long stream locks the loop; silence forces it back to reference.
  task automatic t_stream();
    pgbx_word_t w;
    rclk_n    = 0;
    rclk_seen = rclk;
    for (int i = 0; i < 40; i++) send_word(16'hc3a5 ^ 16'(i * 291));
    idle(4);
    // A change every eight strobes; the last one follows the last sample.
    check(32'(rclk_n), 32'd79);
    check(32'(fref), 32'h0);
    check(32'(pgbx_framer_i.got.size()), 32'd40);
    for (int i = 0; i < 40; i++) begin
      w = pgbx_framer_i.got[i];
      check(32'(w.data), 32'(16'hc3a5 ^ 16'(i * 291)));
    end
    check(32'(pgbx_framer_i.got[0].on_ref), 32'h1);
    check(32'(pgbx_framer_i.got[39].on_ref), 32'h0);
    idle(300);
    check(32'(fref), 32'h1);
    pgbx_framer_i.got.delete();
  endtask : t_stream

  // A stalled sink keeps three words; a fourth overwrites the newest one.
  task automatic t_stall();
    logic [15:0] exp [6];
    exp = '{16'h1111, 16'h2222, 16'h3333, 16'h4444, 16'h5555, 16'h7777};
    stall = 1'b1;
    for (int i = 0; i < 3; i++) send_word(exp[i]);
    idle(4);
    check(32'({valid, ovr}), 32'h2);
    stall = 1'b0;
    idle(6);
    stall = 1'b1;
    send_word(16'h4444);
    send_word(16'h5555);
    send_word(16'h6666);
    send_word(16'h7777);
    idle(4);
    check(32'(ovr), 32'h1);
    stall = 1'b0;
    idle(8);
    check(32'(pgbx_framer_i.got.size()), 32'd6);
    for (int i = 0; i < 6; i++) begin
      check(32'(pgbx_framer_i.got[i].data), 32'(exp[i]));
    end
  endtask : t_stall

  // The derived clock follows the reference while the loop is unlocked.
  task automatic t_refclk();
    int   n;
    logic last;
    n    = 0;
    last = dclk;
    for (int c = 0; c < 44; c++) begin
      refclk = (c % 4 < 2) && (c < 40);
      @(posedge mclk);
      #1;
      if (dclk !== last) n++;
      last = dclk;
    end
    check(32'(fref), 32'h1);
    check(32'(n), 32'd10);
  endtask : t_refclk

  // A latched word leaves MSB first, thirteen cycles after the parallel clock rises.
  task automatic t_tx();
    logic [15:0] w;
    int          n;
    for (int k = 0; k < 2; k++) begin
      n = 0;
      while (!(pclk === 1'b1 && n > 0 && w[0] === 1'b0) && n < 40) begin
        w[0] = pclk;
        @(posedge mclk);
        #1;
        n++;
      end
      w = tdat;
      repeat (13) @(posedge mclk);
      #1;
      for (int i = 15; i >= 0; i--) begin
        check(32'(txs), 32'(w[i]));
        @(posedge mclk);
        #1;
      end
    end
    // First pass finds a rising sample, second counts to the next one.
    for (int k = 0; k < 2; k++) begin
      n    = 0;
      w[0] = 1'b1;
      while (!(w[0] === 1'b0 && bclk === 1'b1) && n < 40) begin
        w[0] = bclk;
        @(posedge mclk);
        #1;
        n++;
      end
    end
    check(32'(n), 32'd16);
  endtask : t_tx

  //----------------------------------------------------------------
  // Main sequence and watchdog
  //----------------------------------------------------------------
  initial begin
    mclk = 1'b0; rst_b = 1'b0; strobe = 1'b0; sdata = 1'b0;
    refclk = 1'b0; stall = 1'b0; rate = RATE_LAN;
    err_count = 0;
    n_checks = 0;
    repeat (2) @(posedge mclk);
    #1;
    check(32'({fref, valid, ovr, txs}), 32'h8);
    check(32'(khz), 32'(LAN_KHZ));
    rst_b = 1'b1;
    t_stream();
    t_rates();
    t_stall();
    t_refclk();
    t_tx();
    close_out();
  end

  // The scenarios need about 1250 cycles.
  initial begin
    #100000;
    err_count++;
    close_out();
  end
endmodule : tb

// File: hw/pgbx_buf.sv
// Two-entry valid/ready buffer for received words.
`timescale 1ns/1ns
module pgbx_buf #(
  parameter int unsigned W = 17
) (
  input  wire logic         mclk,
  input  wire logic         rst_b,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);

  //----------------------------------------------------------------
  // State
  //----------------------------------------------------------------
  typedef struct packed {
    logic [1:0]   cnt;   // Entries held, zero to two.
    logic [W-1:0] s0;    // Head entry, seen at the output.
    logic [W-1:0] s1;    // Second entry.
    logic         vld;   // Head is valid; kept in a flop for the port.
  } pgbx_buf_st_t;

  pgbx_buf_st_t st_ff;   // Registered state.
  pgbx_buf_st_t nxt_st;  // Next state.
  logic         push;    // Word accepted on the filling side.
  logic         pop;     // Word taken on the draining side.

  if (W == 0) begin : g_chk
    $error("pgbx_buf: width must be nonzero.");
  end

  assign in_ready  = (st_ff.cnt != 2'h2);
  assign out_valid = st_ff.vld;
  assign out_data  = st_ff.s0;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Next state; the head always moves up so the output stays a flop.
  always_comb begin
    nxt_st = st_ff;
    if (push && pop) begin
      if (st_ff.cnt == 2'h1) begin
        nxt_st.s0 = in_data;
      end else begin
        nxt_st.s0 = st_ff.s1;
        nxt_st.s1 = in_data;
      end
    end else if (push) begin
      if (st_ff.cnt == 2'h0) begin
        nxt_st.s0 = in_data;
      end else begin
        nxt_st.s1 = in_data;
      end
      nxt_st.cnt = 2'(st_ff.cnt + 2'h1);
    end else if (pop) begin
      nxt_st.s0  = st_ff.s1;
      nxt_st.cnt = 2'(st_ff.cnt - 2'h1);
    end
    // Valid follows the next count so the output needs no decode.
    nxt_st.vld = (nxt_st.cnt != 2'h0);
  end

  // State register.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // A stalled head word must not change under the receiver.
  AST_BUF_HOLD: assert property (@(posedge mclk) disable iff (!rst_b)
    out_valid && !out_ready |=> out_valid && $stable(out_data))
    else $error("Stalled buffer head changed.");

endmodule : pgbx_buf

// File: hw/pgbx_pkg.sv
// Shared constants and types of the 16-bit parallel/serial gearbox.
//------------------------------------------------------------------
// Overview of operation
//------------------------------------------------------------------
// Overview of operation
// - Receive serial bits become 16-bit parallel words.
// - Failed frequency test forces loop onto reference.
// - Recovered bit rate follows the selected rate.
// - Input register captures on parallel clock rising edge.
// - Second register loads in parallel, shifts out serially.
// - Internal byte clock triggers each input-to-shifter load.
// - Load phase is aligned to the parallel input clock.
// - Byte-rate transmit clock is driven upstream.
// - Reference-derived clock runs without receive lock.
package pgbx_pkg;

  //----------------------------------------------------------------
  // Word and bit counting
  //----------------------------------------------------------------
  localparam int unsigned WORD_W   = 16;       // Parallel word width.
  localparam logic [3:0]  BIT_LAST = 4'hf;     // Last bit slot of a word.
  localparam logic [3:0]  BIT_MID  = 4'h7;     // Half-word slot.
  // Counter value forced at a parallel clock capture; the load then
  // follows eleven bit times later, far from the capture edge.
  localparam logic [3:0]  TX_ALIGN_PHASE = 4'h4;

  //----------------------------------------------------------------
  // Recovered bit clock rates in kHz
  //----------------------------------------------------------------
  localparam logic [23:0] LAN_KHZ = 24'h9d_5b34;  // 10312.5 MHz.
  localparam logic [23:0] WAN_KHZ = 24'h97_e000;  // 9953.28 MHz.
  localparam logic [23:0] FEC_KHZ = 24'ha2_b908;  // 10664.2 MHz.

  //----------------------------------------------------------------
  // Frequency test window, counted in clock cycles
  //----------------------------------------------------------------
  localparam logic [8:0] LD_WIN_LAST = 9'h0ff;  // 256-cycle window.
  localparam logic [8:0] LD_MIN_BITS = 9'h0fc;  // Fewest bits allowed.
  localparam logic [8:0] LD_MAX_BITS = 9'h100;  // Most bits allowed.

  // Line rate selection.
  typedef enum logic [1:0] {RATE_LAN, RATE_WAN, RATE_FEC} pgbx_rate_t;

  // Lock detector states.
  typedef enum logic {LD_ON_REF, LD_LOCKED} pgbx_ld_t;

  // Received word with the loop mode it was gathered under.
  typedef struct packed {
    logic                on_ref;
    logic [WORD_W-1:0]   data;
  } pgbx_word_t;

  // State of the gearbox core, receive buffer excepted.
  typedef struct packed {
    pgbx_ld_t            ld;
    logic [8:0]          win_cnt;
    logic [8:0]          bit_tally;
    logic                force_ref;
    logic [23:0]         rate_khz;
    logic [3:0]          rx_cnt;
    logic [WORD_W-1:0]   rx_sh;
    logic                push;
    pgbx_word_t          word;
    logic                rx_pclk;
    logic                overrun;
    logic                ref_q;
    logic                ref_clk;
    logic                pic_q;
    logic [WORD_W-1:0]   tx_in;
    logic [WORD_W-1:0]   tx_sh;
    logic [3:0]          tx_cnt;
    logic                tx_bclk;
  } pgbx_state_t;

endpackage : pgbx_pkg

// File: hw/pgbx_top.sv
// Gearbox core: receive deserializer, lock test and transmit serializer.
`timescale 1ns/1ns
module pgbx_top
  import pgbx_pkg::*;
#(
  parameter int unsigned DATA_W = 16
) (
  input  wire logic                mclk,
  input  wire logic                rst_b,
  input  wire pgbx_pkg::pgbx_rate_t rate_sel,
  input  wire logic                rx_serial_data,
  input  wire logic                rx_bit_strobe,
  input  wire logic                rx_reference_clock,
  input  wire logic                rx_word_ready,
  output logic                     rx_word_valid,
  output pgbx_pkg::pgbx_word_t     rx_parallel_data_out,
  output logic                     rx_parallel_out_clock,
  output logic                     rx_force_ref,
  output logic [23:0]              rx_bit_rate_khz,
  output logic                     rx_overrun,
  output logic                     rx_ref_derived_clock,
  input  wire logic [15:0]         tx_parallel_data_in,
  input  wire logic                tx_parallel_in_clock,
  output logic                     tx_serial_data,
  output logic                     tx_byte_clock_out
);
  import pgbx_pkg::*;

  //----------------------------------------------------------------
  // Declarations
  //----------------------------------------------------------------
  pgbx_state_t st_ff;      // Registered state, receive buffer excepted.
  pgbx_state_t nxt_st;     // Its next value.
  logic [8:0]  tally_now;  // Bits seen in the window, this cycle included.
  logic        tally_ok;   // Window count within the allowed band.
  logic        win_end;    // Last cycle of the test window.
  logic        cap;        // Rising edge of the parallel input clock.
  logic        ref_rise;   // Rising edge of the receive reference.
  logic        tx_load;    // Byte clock slot that loads the shifter.
  logic        buf_ready;  // Buffer can take the pending word.

  // The datapath is built for the documented word width only.
  if (DATA_W != WORD_W) begin : g_chk
    $error("pgbx_top: only a 16-bit word is supported.");
  end

  //----------------------------------------------------------------
  // Edge and window decode
  //----------------------------------------------------------------
  assign tally_now = 9'(st_ff.bit_tally + {8'h00, rx_bit_strobe});
  assign tally_ok  = (tally_now >= LD_MIN_BITS) &&
                     (tally_now <= LD_MAX_BITS);
  assign win_end   = (st_ff.win_cnt == LD_WIN_LAST);
  assign cap       = tx_parallel_in_clock && !st_ff.pic_q;
  assign ref_rise  = rx_reference_clock && !st_ff.ref_q;
  assign tx_load   = (st_ff.tx_cnt == BIT_LAST);

  //----------------------------------------------------------------
  // Next state
  //----------------------------------------------------------------
  // All behaviour but the receive buffer is in this one process; each stage only reads the
  // registered state, but the deserializer's push set must follow the push clear.
  always_comb begin
    nxt_st = st_ff;

    // Recovered bit rate reported for the selected line rate.
    case (rate_sel)
      RATE_WAN: nxt_st.rate_khz = WAN_KHZ;
      RATE_FEC: nxt_st.rate_khz = FEC_KHZ;
      default:  nxt_st.rate_khz = LAN_KHZ;
    endcase

    // Frequency test: bits per fixed window must land in a narrow band.
    nxt_st.win_cnt   = 9'(st_ff.win_cnt + 9'h001);
    nxt_st.bit_tally = tally_now;
    if (win_end) begin
      nxt_st.win_cnt   = 9'h000;
      nxt_st.bit_tally = 9'h000;
      case (st_ff.ld)
        LD_LOCKED: begin
          if (!tally_ok) begin
            // Data lost its rate; steer the loop to the reference.
            nxt_st.ld        = LD_ON_REF;
            nxt_st.force_ref = 1'b1;
          end
        end
        LD_ON_REF: begin
          if (tally_ok) begin
            nxt_st.ld        = LD_LOCKED;
            nxt_st.force_ref = 1'b0;
          end
        end
        default: begin
          nxt_st.ld        = LD_ON_REF;
          nxt_st.force_ref = 1'b1;
        end
      endcase
    end

    // A pending word leaves once the buffer takes it.
    if (st_ff.push && buf_ready) begin
      nxt_st.push = 1'b0;
    end

    // Deserializer: one bit per strobe, MSB first, 16 to a word.
    if (rx_bit_strobe) begin
      nxt_st.rx_sh  = {st_ff.rx_sh[14:0], rx_serial_data};
      nxt_st.rx_cnt = 4'(st_ff.rx_cnt + 4'h1);
      if (st_ff.rx_cnt == BIT_LAST) begin
        // A still unaccepted word is overwritten; flag the loss.
        if (st_ff.push && !buf_ready) begin
          nxt_st.overrun = 1'b1;
        end
        nxt_st.push        = 1'b1;
        nxt_st.word.data   = {st_ff.rx_sh[14:0], rx_serial_data};
        nxt_st.word.on_ref = st_ff.force_ref;
      end
      if (st_ff.rx_cnt == BIT_LAST || st_ff.rx_cnt == BIT_MID) begin
        nxt_st.rx_pclk = !st_ff.rx_pclk;
      end
    end

    // Reference-derived clock never looks at lock or received data.
    nxt_st.ref_q = rx_reference_clock;
    if (ref_rise) begin
      nxt_st.ref_clk = !st_ff.ref_clk;
    end

    // Transmit input register takes all 16 bits on each rising edge.
    nxt_st.pic_q = tx_parallel_in_clock;
    if (cap) begin
      nxt_st.tx_in = tx_parallel_data_in;
    end

    // Bit counter: free running, pulled to a fixed phase at capture.
    if (cap) begin
      nxt_st.tx_cnt = TX_ALIGN_PHASE;
    end else begin
      nxt_st.tx_cnt = 4'(st_ff.tx_cnt + 4'h1);
    end

    // Shifter reloads in the byte clock slot, shifts otherwise.
    if (tx_load) begin
      nxt_st.tx_sh = st_ff.tx_in;
    end else begin
      nxt_st.tx_sh = {st_ff.tx_sh[14:0], 1'b0};
    end

    // Byte-rate clock out: half period of eight bit times.
    if (tx_load || st_ff.tx_cnt == BIT_MID) begin
      nxt_st.tx_bclk = !st_ff.tx_bclk;
    end
  end

  //----------------------------------------------------------------
  // State register
  //----------------------------------------------------------------
  // The loop starts forced to the reference until a window passes.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      st_ff           <= '0;
      st_ff.ld        <= LD_ON_REF;
      st_ff.force_ref <= 1'b1;
      st_ff.rate_khz  <= LAN_KHZ;
    end else begin
      st_ff <= nxt_st;
    end
  end

  //----------------------------------------------------------------
  // Receive buffer
  //----------------------------------------------------------------
  // Two entries let the receiver stall briefly without losing words.
  pgbx_buf #(
    .W ($bits(pgbx_word_t))
  ) u_rx_buf (
    .mclk      (mclk),
    .rst_b     (rst_b),
    .in_valid  (st_ff.push),
    .in_ready  (buf_ready),
    .in_data   (st_ff.word),
    .out_valid (rx_word_valid),
    .out_ready (rx_word_ready),
    .out_data  (rx_parallel_data_out)
  );

  //----------------------------------------------------------------
  // Outputs
  //----------------------------------------------------------------
  assign rx_parallel_out_clock = st_ff.rx_pclk;
  assign rx_force_ref          = st_ff.force_ref;
  assign rx_bit_rate_khz       = st_ff.rate_khz;
  assign rx_overrun            = st_ff.overrun;
  assign rx_ref_derived_clock  = st_ff.ref_clk;
  assign tx_serial_data        = st_ff.tx_sh[15];
  assign tx_byte_clock_out     = st_ff.tx_bclk;

  //----------------------------------------------------------------
  // Assertions
  //----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  AST_RX_WORD: assert property (
    rx_bit_strobe && st_ff.rx_cnt == BIT_LAST |=> st_ff.push &&
    st_ff.word.data == {$past(st_ff.rx_sh[14:0]), $past(rx_serial_data)})
    else $error("Sixteenth bit did not form a word.");

  AST_LD_FORCE: assert property (
    win_end && !tally_ok |=> st_ff.force_ref && st_ff.ld == LD_ON_REF)
    else $error("Failed frequency test did not force reference.");

  AST_RATE: assert property (
    rate_sel == RATE_WAN |=> rx_bit_rate_khz == WAN_KHZ)
    else $error("WAN rate not reported.");

  AST_TX_CAP: assert property (
    cap |=> st_ff.tx_in == $past(tx_parallel_data_in))
    else $error("Parallel input not captured.");

  AST_TX_LOAD: assert property (
    tx_load |=> st_ff.tx_sh == $past(st_ff.tx_in))
    else $error("Shifter did not load in byte slot.");

  AST_TX_SHIFT: assert property (
    !tx_load |=> tx_serial_data == $past(st_ff.tx_sh[14]))
    else $error("Shifter did not advance one bit.");

  AST_TX_ALIGN: assert property (
    cap |=> st_ff.tx_cnt == TX_ALIGN_PHASE ##11 tx_load)
    else $error("Load phase not aligned to input clock.");

  AST_TX_BCLK: assert property (
    tx_load |=> tx_byte_clock_out != $past(tx_byte_clock_out))
    else $error("Byte clock did not toggle at word slot.");

  AST_REF_CLK: assert property (
    ref_rise |=> rx_ref_derived_clock != $past(rx_ref_derived_clock))
    else $error("Reference-derived clock stalled.");

endmodule : pgbx_top
